// ==== design/ceh_event_unit.sv ====
// Event acceptance, context save/restore and handler dispatch of the core
// What this block does
// - Higher-priority pending events preempt handling of lower-priority ones.
// - Handlers sit at fixed offsets from the vector base, mostly four bytes apart.
// - Autovector offset from the interrupt controller is 14 bits wide.
// - Handler address is vector base OR offset, never their sum.
// - Event acceptance runs as one uninterruptible sequence.
// - Masked events are not accepted; level, exception and global masks gate classes.
// - NMI, unrecoverable, MPU multiple hit and bus errors ignore all masks.
// - Interrupt acceptance sets masks of its own and lower levels; other events set all masks.
// - Acceptance pushes status and PC, plus R8-R12 and LR for interrupts.
// - Accepting an exception sets exception and global mask bits.
// - After saving, mode and bank follow the event and PC takes handler.
// - Event return pops status and PC, plus R8-R12 and LR for interrupts.
// - Supervisor call pushes return address and status; its return restores both.
// - External interrupts use autovectored entries relative to the vector base.
// - After reset fetching starts at the fixed reset address.
// - Events of the oldest pipeline instruction are handled first.
// - Debug entry is suppressed while the debug-entry mask is set.
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ceh_event_unit
    import ceh_pkg::*;
#(
    parameter int STACK_AW = 6
) (
    input wire logic SYS_CLK_I,                  // Core clock, 20 MHz
    input wire logic ARST_N_I,                   // Asynchronous reset, active low
    input wire logic [4:0] AVS_ADDRESS_I,        // Avalon byte address
    input wire logic AVS_READ_I,                 // Avalon read
    input wire logic AVS_WRITE_I,                // Avalon write
    input wire logic [31:0] AVS_WRITEDATA_I,     // Avalon write data
    input wire logic [3:0] AVS_BYTEENABLE_I,     // Avalon byte enables
    output logic [31:0] AVS_READDATA_O,          // Avalon read data
    output logic AVS_WAITREQUEST_O,              // Avalon wait request
    input wire logic [25:0] EXC_OLD_I,           // Exceptions of oldest instruction
    input wire logic [25:0] EXC_YNG_I,           // Exceptions of younger instruction
    input wire logic NMI_I,                      // Non-maskable interrupt request
    input wire logic [3:0] IRQ_I,                // Interrupt level requests
    input wire logic [13:0] IRQ_OFFS_I,          // Autovector offset of top level
    input wire logic DBG_REQ_I,                  // Debug request
    input wire logic [31:0] DBG_ADDR_I,          // Debug handler address
    input wire logic RETE_I,                     // Event return instruction
    input wire logic RETS_I,                     // Supervisor return instruction
    input wire logic SCALL_I,                    // Supervisor call instruction
    input wire logic RETD_I,                     // Debug return instruction
    input wire logic [31:0] CTX_PC_I,            // Return address of current context
    input wire logic [31:0] CTX_GPR_I,           // Register selected by GPR_SEL_O
    output logic [2:0] GPR_SEL_O,                // 0..4 R8..R12, 5 LR
    output logic GPR_WE_O,                       // Restore strobe for GPR_SEL_O
    output logic [31:0] GPR_WDATA_O,             // Restored register value
    output logic [31:0] PC_O,                    // Program counter to load
    output logic PC_LOAD_O,                      // Load pulse for PC_O
    output logic [31:0] SR_O,                    // Status register
    output logic [2:0] BANK_O,                   // Register bank select
    output logic BUSY_O,                         // Sequence running, stall pipeline
    output logic ACK_O,                          // Event accepted pulse
    output logic [4:0] ACK_EVT_O,                // Index of accepted event
    output logic [3:0] IRQ_ACK_O,                // Per-level acceptance pulse
    output logic DBG_ENTER_O                     // Debug entry pulse
);

    // ********************************************************************
    // State
    // ********************************************************************
    ceh_state_type state_ff, nxt_state;
    logic [31:0] sr_ff, vb_ff, sp_ff, pc_ff, tgt_ff, nsr_ff, rpc_ff;
    logic [31:0] drsr_ff, drar_ff, rdata_ff;
    logic [4:0] evt_ff;
    logic [2:0] cnt_ff, last_ff;
    logic pc_load_ff, dbg_ff, rsp_ff, evtk_ff;

    // ********************************************************************
    // Register bus decode
    // ********************************************************************
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // One wait cycle per access in idle, more while a sequence runs; writes land at the edge waitrequest is low
    wire acc = AVS_READ_I | AVS_WRITE_I;
    wire sw_wr = AVS_WRITE_I & rsp_ff;
    wire wr_sr = sw_wr & (AVS_ADDRESS_I == REG_SR);
    wire wr_vb = sw_wr & (AVS_ADDRESS_I == REG_VB);
    wire wr_sp = sw_wr & (AVS_ADDRESS_I == REG_SSP);
    wire idle = (state_ff == ST_IDLE);
    wire [31:0] stat_w = {19'h0_0000, evt_ff, 7'h00, ~idle};
    wire [31:0] rd_w = (AVS_ADDRESS_I == REG_SR) ? sr_ff :
                       (AVS_ADDRESS_I == REG_VB) ? vb_ff :
                       (AVS_ADDRESS_I == REG_SSP) ? sp_ff :
                       (AVS_ADDRESS_I == REG_STAT) ? stat_w : 32'h0000_0000;
    assign AVS_WAITREQUEST_O = acc & ~rsp_ff;
    assign AVS_READDATA_O = rdata_ff;

    // ********************************************************************
    // Event gathering and masking
    // ********************************************************************
    wire [2:0] mode = sr_ff[SR_M_LSB +: 3];
    wire old_any = |(EXC_OLD_I & EVT_SYNC);
    // Oldest instruction wins even over higher-priority younger events
    wire [25:0] sync_req = (old_any ? EXC_OLD_I : EXC_YNG_I) & EVT_SYNC;
    wire [25:0] req = sync_req | {17'h0_0000, IRQ_I[0], IRQ_I[1], IRQ_I[2], IRQ_I[3],
                                  NMI_I, 4'h0};
    logic [25:0] ok;

    // Acceptability per event: critical ones bypass masks, others gated
    for (genvar i = 0; i < EVT_NUM; i++) begin : g_ok
        if (i < EVT_NMI) begin : g_crit
            assign ok[i] = req[i];
        end else if (i == EVT_NMI) begin : g_nmi
            assign ok[i] = req[i] & (mode != MODE_NMI);
        end else if (i <= EVT_IRQ0) begin : g_irq
            localparam logic [2:0] LM = MODE_IRQ_LEVEL_0 + 3'(EVT_IRQ0 - i);
            assign ok[i] = req[i] & ~sr_ff[SR_GM] & ~sr_ff[SR_I0M + EVT_IRQ0 - i]
                           & (mode < LM);
        end else begin : g_exc
            assign ok[i] = req[i] & ~sr_ff[SR_EM];
        end
    end

    // Priority encoder, lowest index wins
    logic [4:0] sel;
    always_comb begin
        sel = 5'h00;
        for (int i = EVT_NUM - 1; i >= 0; i--) begin
            if (ok[i]) begin
                sel = 5'(i);
            end
        end
    end
    wire found = |ok;
    wire sel_irq = (sel >= 5'(EVT_IRQ3)) & (sel <= 5'(EVT_IRQ0));
    wire [4:0] lvl_w = 5'(EVT_IRQ0) - sel;
    wire [1:0] lvl = lvl_w[1:0];

    // Handler address: table offset or autovector, ORed onto the base
    wire [31:0] offs_w = sel_irq ? {18'h0_0000, IRQ_OFFS_I} : evt_offs(sel);
    wire [31:0] tgt_w = vb_ff | offs_w;

    // New status on acceptance: mode, plus masks of equal or lower levels for interrupts, all masks otherwise
    logic [31:0] nsr_evt;
    always_comb begin
        nsr_evt = sr_ff;
        if (sel_irq) begin
            nsr_evt[SR_M_LSB +: 3] = MODE_IRQ_LEVEL_0 + {1'b0, lvl};
            for (int j = 0; j < 4; j++) begin
                if (2'(j) <= lvl) begin
                    nsr_evt[SR_I0M + j] = 1'b1;
                end
            end
        end else begin
            nsr_evt[SR_M_LSB +: 3] = (sel == 5'(EVT_NMI)) ? MODE_NMI : MODE_EXC;
            nsr_evt[SR_I0M +: 4] = 4'hF;
            nsr_evt[SR_EM] = 1'b1;
            nsr_evt[SR_GM] = 1'b1;
        end
    end

    // ********************************************************************
    // Start decisions in idle; a bus write in flight holds events one cycle
    // ********************************************************************
    wire idle_ok = idle & ~rsp_ff;
    wire go_dbg = DBG_REQ_I & ~sr_ff[SR_DM] & ~sr_ff[SR_D];
    wire t_dbg = idle_ok & go_dbg;
    wire t_evt = idle_ok & ~go_dbg & found;
    wire t_cmd = idle_ok & ~go_dbg & ~found;
    wire t_retd = t_cmd & RETD_I & sr_ff[SR_D];
    wire t_rete = t_cmd & ~t_retd & RETE_I;
    wire t_rets = t_cmd & ~t_retd & ~RETE_I & RETS_I;
    wire t_scall = t_cmd & ~t_retd & ~RETE_I & ~RETS_I & SCALL_I;
    wire in_irq = (mode >= MODE_IRQ_LEVEL_0) & (mode <= MODE_IRQ_LEVEL_3);
    logic [31:0] nsr_sc;
    always_comb begin
        nsr_sc = sr_ff;
        if (mode == MODE_APP) begin
            nsr_sc[SR_M_LSB +: 3] = MODE_SUP;
        end
    end

    // ********************************************************************
    // Stack datapath
    // ********************************************************************
    wire [2:0] pi = last_ff - cnt_ff;
    wire [2:0] cm2 = cnt_ff - 3'h2;
    wire [2:0] pm2 = pi - 3'h2;
    wire [31:0] sp_dec = sp_ff - 32'h0000_0004;
    wire [31:0] sp_inc = sp_ff + 32'h0000_0004;
    wire [31:0] push_w = (cnt_ff == 3'h0) ? rpc_ff :
                         (cnt_ff == 3'h1) ? sr_ff : CTX_GPR_I;
    wire [31:0] pop_w;
    wire pushing = (state_ff == ST_PUSH);
    wire pop_d = (state_ff == ST_POP_D);

    ceh_stack_mem #(
        .AW(STACK_AW),
        .DW(32)
    ) u_stack (
        .clk_i(SYS_CLK_I),
        .arst_n_i(ARST_N_I),
        .we_i(pushing),
        .waddr_i(sp_dec[STACK_AW+1:2]),
        .wdata_i(push_w),
        .raddr_i(sp_ff[STACK_AW+1:2]),
        .rdata_o(pop_w)
    );

    // Register file side of save and restore
    assign GPR_SEL_O = pushing ? cm2 : pm2;
    assign GPR_WE_O = pop_d & (pi >= 3'h2);
    assign GPR_WDATA_O = pop_w;

    // ********************************************************************
    // Sequencer: push, jump and pop run without admitting other events
    // ********************************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RST: nxt_state = ST_IDLE;
            ST_IDLE: begin
                if (t_evt | t_scall) begin
                    nxt_state = ST_PUSH;
                end else if (t_rete | t_rets) begin
                    nxt_state = ST_POP_A;
                end
            end
            ST_PUSH: nxt_state = (cnt_ff == last_ff) ? ST_JUMP : ST_PUSH;
            ST_JUMP: nxt_state = ST_IDLE;
            ST_POP_A: nxt_state = ST_POP_D;
            ST_POP_D: nxt_state = (cnt_ff == last_ff) ? ST_IDLE : ST_POP_A;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_ff <= ST_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Word counter of push and pop
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cnt_ff <= 3'h0;
        end else if (idle) begin
            cnt_ff <= 3'h0;
        end else if (pushing | pop_d) begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end

    // Capture of the accepted event or call
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            evt_ff <= 5'h00;
            tgt_ff <= 32'h0000_0000;
            nsr_ff <= SR_RESET;
            rpc_ff <= 32'h0000_0000;
            last_ff <= 3'h1;
            evtk_ff <= 1'b0;
        end else if (t_evt) begin
            evt_ff <= sel;
            tgt_ff <= tgt_w;
            nsr_ff <= nsr_evt;
            rpc_ff <= CTX_PC_I;
            last_ff <= sel_irq ? 3'h7 : 3'h1;
            evtk_ff <= 1'b1;
        end else if (t_scall) begin
            tgt_ff <= vb_ff | SCALL_OFFS;
            nsr_ff <= nsr_sc;
            rpc_ff <= CTX_PC_I;
            last_ff <= 3'h1;
            evtk_ff <= 1'b0;
        end else if (t_rete | t_rets) begin
            last_ff <= (t_rete & in_irq) ? 3'h7 : 3'h1;
        end
    end

    // System stack pointer
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sp_ff <= 32'h0000_0000;
        end else if (wr_sp) begin
            sp_ff <= be_merge(sp_ff, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        end else if (pushing) begin
            sp_ff <= sp_dec;
        end else if (pop_d) begin
            sp_ff <= sp_inc;
        end
    end

    // Status register
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sr_ff <= SR_RESET;
        end else if (wr_sr) begin
            sr_ff <= be_merge(sr_ff, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        end else if (state_ff == ST_JUMP) begin
            sr_ff <= nsr_ff;
        end else if (pop_d & (pi == 3'h1)) begin
            sr_ff <= pop_w;
        end else if (t_dbg) begin
            sr_ff <= {sr_ff[31:27], 1'b1, sr_ff[25], MODE_EXC, sr_ff[21:0]};
        end else if (t_retd) begin
            sr_ff <= drsr_ff;
        end
    end

    // Program counter and its load pulse
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pc_ff <= 32'h0000_0000;
            pc_load_ff <= 1'b0;
        end else begin
            pc_load_ff <= (state_ff == ST_RST) | (state_ff == ST_JUMP) | t_dbg | t_retd
                          | (pop_d & (pi == 3'h0));
            if (state_ff == ST_RST) begin
                pc_ff <= RESET_ADDR;
            end else if (state_ff == ST_JUMP) begin
                pc_ff <= tgt_ff;
            end else if (pop_d & (pi == 3'h0)) begin
                pc_ff <= pop_w;
            end else if (t_dbg) begin
                pc_ff <= DBG_ADDR_I;
            end else if (t_retd) begin
                pc_ff <= drar_ff;
            end
        end
    end

    // Vector base and debug return registers
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            vb_ff <= 32'h0000_0000;
            drsr_ff <= 32'h0000_0000;
            drar_ff <= 32'h0000_0000;
            dbg_ff <= 1'b0;
        end else begin
            dbg_ff <= t_dbg;
            if (wr_vb) begin
                vb_ff <= be_merge(vb_ff, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
            end
            if (t_dbg) begin
                drsr_ff <= sr_ff;
                drar_ff <= CTX_PC_I;
            end
        end
    end

    // Bus answer phase and read data
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rsp_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            rsp_ff <= acc & ~rsp_ff & idle;
            if (AVS_READ_I & ~rsp_ff) begin
                rdata_ff <= rd_w;
            end
        end
    end

    // ********************************************************************
    // Outputs; sources drop their request on the acknowledge
    // ********************************************************************
    assign PC_O = pc_ff;
    assign PC_LOAD_O = pc_load_ff;
    assign SR_O = sr_ff;
    assign BANK_O = mode;
    assign BUSY_O = ~idle;
    assign ACK_O = (state_ff == ST_JUMP) & evtk_ff;
    assign ACK_EVT_O = evt_ff;
    assign DBG_ENTER_O = dbg_ff;
    for (genvar l = 0; l < 4; l++) begin : g_iack
        assign IRQ_ACK_O[l] = ACK_O & (evt_ff == 5'(EVT_IRQ0 - l));
    end

endmodule

// ==== design/ceh_pkg.sv ====
// Constants, status-register layout, event table and state type of the event unit
package ceh_pkg;

    // ********************************************************************
    // Reset values and status-register fields
    // ********************************************************************
    localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
    localparam logic [31:0] SR_RESET = 32'h0061_0000;   // Supervisor, EM and GM set
    localparam int SR_GM = 16;                           // global_mask_bit
    localparam int SR_I0M = 17;                          // irq_level0_mask, levels 1..3 follow
    localparam int SR_EM = 21;                           // exception_mask_bit
    localparam int SR_M_LSB = 22;                        // Three mode bits
    localparam int SR_D = 26;                            // Debug state
    localparam int SR_DM = 27;                           // debug_entry_mask

    // ********************************************************************
    // Mode codes, one per execution context
    // ********************************************************************
    localparam logic [2:0] MODE_APP = 3'h0;
    localparam logic [2:0] MODE_SUP = 3'h1;
    localparam logic [2:0] MODE_IRQ_LEVEL_0 = 3'h2;
    localparam logic [2:0] MODE_IRQ_LEVEL_3 = 3'h5;
    localparam logic [2:0] MODE_EXC = 3'h6;
    localparam logic [2:0] MODE_NMI = 3'h7;

    // ********************************************************************
    // Event indices, index 0 is the highest priority
    // ********************************************************************
    localparam int EVT_NUM = 26;
    localparam int EVT_NMI = 4;                          // 0..4 can never be masked
    localparam int EVT_IRQ3 = 5;
    localparam int EVT_IRQ0 = 8;
    localparam logic [25:0] EVT_SYNC = 26'h1F8_FE0F;     // Pipeline-reported, in use
    localparam int IRQ_OFFS_W = 14;
    localparam logic [31:0] SCALL_OFFS = 32'h0000_0100;

    // ********************************************************************
    // Register map on the Avalon slave (byte addresses)
    // ********************************************************************
    localparam logic [4:0] REG_SR = 5'h00;
    localparam logic [4:0] REG_VB = 5'h04;
    localparam logic [4:0] REG_SSP = 5'h08;
    localparam logic [4:0] REG_STAT = 5'h0C;

    // ********************************************************************
    // Sequencer states
    // ********************************************************************
    typedef enum logic [5:0] {
        ST_RST = 6'h01,
        ST_IDLE = 6'h02,
        ST_PUSH = 6'h04,
        ST_JUMP = 6'h08,
        ST_POP_A = 6'h10,
        ST_POP_D = 6'h20
    } ceh_state_type;

    // Fixed handler offset of each non-autovectored event
    function automatic logic [31:0] evt_offs(input logic [4:0] idx);
        case (idx)
            5'h01: evt_offs = 32'h0000_0004;
            5'h02: evt_offs = 32'h0000_0008;
            5'h03: evt_offs = 32'h0000_000C;
            5'h04: evt_offs = 32'h0000_0010;
            5'h09: evt_offs = 32'h0000_0014;
            5'h0A: evt_offs = 32'h0000_0050;
            5'h0B: evt_offs = 32'h0000_0018;
            5'h0C: evt_offs = 32'h0000_001C;
            5'h0D: evt_offs = 32'h0000_0020;
            5'h0E: evt_offs = 32'h0000_0024;
            5'h0F: evt_offs = 32'h0000_0028;
            5'h13: evt_offs = 32'h0000_0034;
            5'h14: evt_offs = 32'h0000_0038;
            5'h15: evt_offs = 32'h0000_0060;
            5'h16: evt_offs = 32'h0000_0070;
            5'h17: evt_offs = 32'h0000_003C;
            5'h18: evt_offs = 32'h0000_0040;
            default: evt_offs = 32'h0000_0000;
        endcase
    endfunction

endpackage

// ==== design/ceh_stack_mem.sv ====
// Small system-stack memory with registered read data
`timescale 1ns/1ps
module ceh_stack_mem #(
    parameter int AW = 6,
    parameter int DW = 32
) (
    input wire logic clk_i,              // Core clock
    input wire logic arst_n_i,           // Asynchronous reset, active low
    input wire logic we_i,               // Write strobe
    input wire logic [AW-1:0] waddr_i,   // Write word address
    input wire logic [DW-1:0] wdata_i,   // Write data
    input wire logic [AW-1:0] raddr_i,   // Read word address
    output logic [DW-1:0] rdata_o        // Read data, one cycle after address
);

    logic [DW-1:0] mem_ff [2**AW];

    // Storage array, no reset needed
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_ff[waddr_i] <= wdata_i;
        end
    end

    // Registered read port
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_ff[raddr_i];
        end
    end

endmodule

// ==== sim/ceh_event_unit_assertions.sv ====
// Port checker of the event unit
`timescale 1ns/1ps
module ceh_event_unit_assertions
    import ceh_pkg::*;
(
    input wire logic SYS_CLK_I, // Clock
    input wire logic ARST_N_I, // Reset
    input wire logic [31:0] PC_O, // PC
    input wire logic PC_LOAD_O, // Load
    input wire logic [31:0] SR_O, // Status
    input wire logic BUSY_O, // Busy
    input wire logic ACK_O, // Accept
    input wire logic [4:0] ACK_EVT_O, // Event
    input wire logic [3:0] IRQ_ACK_O // Levels
);
    // One clock domain, checks paused in reset
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    property p_boot; $rose(ARST_N_I) |=> PC_LOAD_O && PC_O == RESET_ADDR; endproperty
    a_boot: assert property (p_boot) else $error("boot");
    property p_seq; ACK_O |-> BUSY_O ##1 PC_LOAD_O && !BUSY_O; endproperty
    a_seq: assert property (p_seq) else $error("seq");
    property p_push; |IRQ_ACK_O |-> $past(BUSY_O, 8) && !$past(BUSY_O, 9); endproperty
    a_push: assert property (p_push) else $error("push");
    property p_exc; ACK_O && (ACK_EVT_O < 5'h04 || ACK_EVT_O > 5'h08)
        |=> SR_O[SR_EM] && SR_O[SR_GM]; endproperty
    a_exc: assert property (p_exc) else $error("exc");
    property p_lvl; IRQ_ACK_O[2] |=> &SR_O[SR_I0M+2:SR_I0M]; endproperty
    a_lvl: assert property (p_lvl) else $error("lvl");
    property p_mode; IRQ_ACK_O[3] |=> SR_O[24:22] == MODE_IRQ_LEVEL_3; endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_mask; |IRQ_ACK_O |-> !SR_O[SR_GM]; endproperty
    a_mask: assert property (p_mask) else $error("mask");
    property p_nmi; ACK_O && ACK_EVT_O == 5'h04 |=> SR_O[24:22] == MODE_NMI; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi");
endmodule
bind ceh_event_unit ceh_event_unit_assertions ceh_event_unit_assertions_inst (
    .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .PC_O(PC_O), .PC_LOAD_O(PC_LOAD_O),
    .SR_O(SR_O), .BUSY_O(BUSY_O), .ACK_O(ACK_O), .ACK_EVT_O(ACK_EVT_O), .IRQ_ACK_O(IRQ_ACK_O));

// ==== sim/ceh_intc_model.sv ====
// Interrupt controller model
`timescale 1ns/1ps
module ceh_intc_model (
    input wire logic clk_i, // Clock
    input wire logic arst_n_i, // Reset
    input wire logic [3:0] set_i, // Raise
    input wire logic [3:0] ack_i, // Accept
    output logic [3:0] irq_o, // Requests
    output logic [13:0] offs_o // Offset
);
    logic [3:0] pend_ff;
    // Requests stay up until accepted
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) pend_ff <= 4'h0;
        else pend_ff <= (pend_ff | set_i) & ~ack_i;
    end
    assign irq_o = pend_ff;
    // Top level wins and shows its offset
    assign offs_o = pend_ff[3] ? 14'h3FFC : pend_ff[2] ? 14'h0200 : pend_ff[1] ? 14'h0108
        : 14'h0080;
endmodule

// ==== sim/tb_cpu_event_handling_unit.sv ====
// Bench of the event unit
`timescale 1ns/1ps
module tb_cpu_event_handling_unit;
    import ceh_pkg::*;
    localparam logic [31:0] VB = 32'h2000_0104;
    localparam logic [31:0] SE = 32'h0040_0000;
    localparam logic [31:0] CX = 32'h1234_5678;
    localparam logic [4:0] RI [8] = '{5'h00, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h15, 5'h18};
    localparam logic [15:0] RO [8] = '{16'h0, 16'h8, 16'h10, 16'h3FFC, 16'h80, 16'h50, 16'h60,
        16'h40};
    logic clk = 0, rn = 0, rd = 0, wr = 0, nm = 0, dq = 0, wq, by, ak, pl;
    logic [2:0] in = '0, gs;
    logic [4:0] ad = '0, ae;
    logic [31:0] wd = '0, q, rt, pc, sr;
    logic [51:0] ex = '0;
    logic [3:0] st = '0, iq, ia;
    logic [13:0] of;
    int mismatches = 0, tests_run = 0, cyc = 0, k;
    always #25 clk = ~clk;
    ceh_intc_model ceh_intc_model_inst (.clk_i(clk), .arst_n_i(rn), .set_i(st), .ack_i(ia),
        .irq_o(iq), .offs_o(of));
    ceh_event_unit ceh_event_unit_inst (.SYS_CLK_I(clk), .ARST_N_I(rn), .AVS_ADDRESS_I(ad),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(rt), .AVS_WAITREQUEST_O(wq), .EXC_OLD_I(ex[25:0]), .EXC_YNG_I(ex[51:26]),
        .NMI_I(nm), .IRQ_I(iq), .IRQ_OFFS_I(of), .DBG_REQ_I(dq), .DBG_ADDR_I(32'h0),
        .RETE_I(in[2]), .RETS_I(in[1]), .SCALL_I(in[0]), .RETD_I(1'b0), .CTX_PC_I(CX),
        .CTX_GPR_I({29'h0, gs}), .GPR_SEL_O(gs), .GPR_WE_O(), .GPR_WDATA_O(), .PC_O(pc),
        .PC_LOAD_O(pl), .SR_O(sr), .BANK_O(), .BUSY_O(by), .ACK_O(ak), .ACK_EVT_O(ae),
        .IRQ_ACK_O(ia), .DBG_ENTER_O());
    task automatic chk(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Avalon access held until the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        {rd, wr, ad, wd} <= {!w, w, a, d};
        do @(posedge clk); while (wq);
        q = rt;
        {rd, wr} <= 2'h0;
    endtask
    // Event or instruction held until taken, then wait for the PC load
    task automatic go(input logic [51:0] e, input logic n, input logic [3:0] r, input logic [2:0] s);
        @(posedge clk);
        {ex, nm, st, in} <= {e, n, r, s};
        @(posedge clk);
        st <= 4'h0;
        do @(negedge clk); while (!(ak || (s != 0 && by)));
        @(posedge clk);
        {ex, nm, in} <= '0;
        do @(negedge clk); while (!pl);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            finish_test;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) rn = 1;
        repeat (2) @(negedge clk);
        chk(sr, SR_RESET);
        chk(pc, RESET_ADDR);
        bus(1, REG_VB, VB);
        bus(0, REG_VB, 0);
        chk(q, VB);
        bus(0, 5'h10, 0);
        chk(q, 0);
        $display("reset and bus done");
        for (int i = 0; i < 8; i++) begin
            bus(1, REG_SR, RI[i] < 5 ? SE | 32'h003F_0000 : SE);
            go((RI[i] < 4 || RI[i] > 8) ? 52'h1 << RI[i] : 52'h0, RI[i] == 4,
                (RI[i] > 4 && RI[i] < 9) ? 4'h1 << (8 - RI[i]) : 4'h0, 3'h0);
            chk(pc, VB | RO[i]);
            chk(ae, RI[i]);
            $display("row %0d done", i);
        end
        bus(1, REG_SR, SE | 32'h0001_0000);
        @(posedge clk) st <= 4'h2;
        @(posedge clk) st <= 4'h0;
        k = 0;
        repeat (20) @(negedge clk) k += ak;
        chk(k, 0);
        bus(1, REG_SR, SE);
        go(0, 0, 0, 0);
        chk(pc, VB | 32'h0108);
        go(0, 0, 4'h4, 0);
        chk(pc, VB | 32'h0200);
        go(0, 0, 0, 3'h4);
        chk(pc, CX);
        chk(sr, 32'h00C6_0000);
        go(0, 0, 0, 3'h1);
        chk(pc, VB | SCALL_OFFS);
        go(0, 0, 0, 3'h2);
        chk(pc, CX);
        $display("nest and return done");
        bus(1, REG_SR, SE);
        go({26'h1, 26'h2000}, 0, 0, 0);
        chk(pc, VB | 32'h0020);
        $display("age order done");
        bus(1, REG_SR, SE | 32'h0800_0000);
        dq <= 1'b1;
        k = 0;
        repeat (8) @(negedge clk) k += pl;
        chk(k, 0);
        dq <= 1'b0;
        finish_test;
    end
endmodule
